// ===== rtl/uart_mode_consts.vh
// Constants for the serial port mode-control block.
// Included by the block's design file; holds definitions only.
`ifndef UART_MODE_CONSTS_VH
`define UART_MODE_CONSTS_VH

// Register map (byte addresses)
`define MODE_REG_ADDR 4'h0
`define PIN_STATUS_ADDR 4'h4
`define ADDR_DEC_W 4

// Mode register field positions
`define BIT_PORT_ENABLE 15
`define BIT_STOP_IN_IDLE 13
`define BIT_INFRARED 12
`define BIT_REQ_PIN_MODE 11
`define PIN_SEL_HI 9
`define PIN_SEL_LO 8
`define BIT_WAKE 7
`define BIT_LOOPBACK 6
`define BIT_AUTO_RATE 5
`define BIT_RX_INVERT 4
`define BIT_HIGH_SPEED 3
`define PAR_HI 2
`define PAR_LO 1
`define BIT_STOP_SEL 0

// Writable bits; everything else reads zero
`define MODE_WRITE_MASK 32'h0000BBFF
`define MODE_RESET 32'h00000000

// Pin-use codes
`define PIN_TX_RX 2'h0
`define PIN_TX_RX_RTS 2'h1
`define PIN_TX_RX_CTS_RTS 2'h2
`define PIN_TX_RX_BCLK 2'h3

// AHB encodings
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'h0

`endif

// ===== rtl/uart_mode_control.v
// Mode-control logic of an asynchronous serial port with an AHB-Lite slave.
// Assumes one 40 MHz clock, core serial logic and GPIO outside this block.
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "uart_mode_consts.vh"

module uart_mode_control (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // System state and core signals
    input wire device_idle,
    input wire device_sleep,
    input wire transmit_enable,
    input wire peripheral_pin_remap,
    input wire core_tx_data,
    input wire core_rts,
    input wire core_bclk,
    input wire serial_receive_pin,
    input wire clear_to_send_pin,
    // Pin ownership and routing
    output reg tx_pin_own,
    output reg rx_pin_own,
    output reg rts_pin_own,
    output reg cts_pin_own,
    output reg bclk_pin_own,
    output reg serial_transmit_pin,
    output reg request_to_send_pin,
    output reg baud_clock_pin,
    output reg core_rx_data,
    output reg core_cts,
    // Core control
    output reg core_run,
    output reg infrared_codec_enable,
    output reg request_pin_mode,
    output reg wake_request,
    output reg loopback_select,
    output reg auto_rate_detect,
    output reg receive_polarity_invert,
    output reg high_speed_rate,
    output reg [1:0] parity_width_select,
    output reg stop_bits_select
);

    // ==========================================================
    // Bus slave
    // ==========================================================
    reg [31:0] serial_port_mode_reg;
    reg wr_pend_reg;
    reg [`ADDR_DEC_W-1:0] addr_reg;
    reg [31:0] rd_next;
    wire take;

    assign take = hsel & hready & (htrans == `HTRANS_NONSEQ);

    // Capture the address phase; every transfer is zero-wait
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= {`ADDR_DEC_W{1'b0}};
            hreadyout <= 1'b1;
            hresp <= `HRESP_OKAY;
        end else begin
            wr_pend_reg <= take & hwrite;
            if (take) begin
                addr_reg <= haddr[`ADDR_DEC_W-1:0];
            end
        end
    end

    // Writes land in the data phase; unimplemented bits never store
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_port_mode_reg <= `MODE_RESET;
        end else if (wr_pend_reg && addr_reg == `MODE_REG_ADDR) begin
            serial_port_mode_reg <= hwdata & `MODE_WRITE_MASK;
        end
    end

    // Read mux; a pin status word shows who owns each pin
    always @* begin
        if (haddr[`ADDR_DEC_W-1:0] == `MODE_REG_ADDR) begin
            rd_next = serial_port_mode_reg & `MODE_WRITE_MASK;
        end else if (haddr[`ADDR_DEC_W-1:0] == `PIN_STATUS_ADDR) begin
            rd_next = {26'h0000000, core_run, bclk_pin_own, cts_pin_own,
                       rts_pin_own, rx_pin_own, tx_pin_own};
        end else begin
            rd_next = 32'h00000000;
        end
    end

    // Read data registered so it stands through the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            hrdata <= rd_next;
        end
    end

    // ==========================================================
    // Mode decode
    // ==========================================================
    wire port_on;
    wire [1:0] pin_sel;
    reg own_tx, own_rx, own_rts, own_cts, own_bclk;

    assign port_on = serial_port_mode_reg[`BIT_PORT_ENABLE];
    assign pin_sel = serial_port_mode_reg[`PIN_SEL_HI:`PIN_SEL_LO];

    // Pin ownership; the remap input overrides the legacy select and keeps rx, rts and cts but not bclk
    always @* begin
        own_tx = 1'b0;
        own_rx = 1'b0;
        own_rts = 1'b0;
        own_cts = 1'b0;
        own_bclk = 1'b0;
        if (port_on) begin
            own_tx = transmit_enable;
            own_rx = 1'b1;
            if (peripheral_pin_remap) begin
                own_rts = 1'b1;
                own_cts = 1'b1;
            end else begin
                case (pin_sel)
                    `PIN_TX_RX_BCLK: begin
                        own_bclk = 1'b1;
                    end
                    `PIN_TX_RX_CTS_RTS: begin
                        own_cts = 1'b1;
                        own_rts = 1'b1;
                    end
                    `PIN_TX_RX_RTS: begin
                        own_rts = 1'b1;
                    end
                    default: begin
                        own_rts = 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    // Pin ownership, core_run, infrared and wake drop to a quiet state while the port is off, to save power
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_pin_own <= 1'b0;
            rx_pin_own <= 1'b0;
            rts_pin_own <= 1'b0;
            cts_pin_own <= 1'b0;
            bclk_pin_own <= 1'b0;
            serial_transmit_pin <= 1'b1;
            request_to_send_pin <= 1'b1;
            baud_clock_pin <= 1'b0;
            core_rx_data <= 1'b1;
            core_cts <= 1'b0;
            core_run <= 1'b0;
            infrared_codec_enable <= 1'b0;
            request_pin_mode <= 1'b0;
            wake_request <= 1'b0;
            loopback_select <= 1'b0;
            auto_rate_detect <= 1'b0;
            receive_polarity_invert <= 1'b0;
            high_speed_rate <= 1'b0;
            parity_width_select <= 2'h0;
            stop_bits_select <= 1'b0;
        end else begin
            tx_pin_own <= own_tx;
            rx_pin_own <= own_rx;
            rts_pin_own <= own_rts;
            cts_pin_own <= own_cts;
            bclk_pin_own <= own_bclk;
            // Loopback keeps the line idle-high outside and feeds the core itself
            if (serial_port_mode_reg[`BIT_LOOPBACK]) begin
                serial_transmit_pin <= 1'b1;
                core_rx_data <= core_tx_data;
                core_cts <= 1'b0;
            end else begin
                serial_transmit_pin <= core_tx_data;
                core_rx_data <= own_rx ? serial_receive_pin : 1'b1;
                core_cts <= own_cts ? clear_to_send_pin : 1'b0;
            end
            request_to_send_pin <= own_rts ? core_rts : 1'b1;
            baud_clock_pin <= own_bclk & core_bclk;
            core_run <= port_on & ~(device_idle & serial_port_mode_reg[`BIT_STOP_IN_IDLE]);
            infrared_codec_enable <= port_on & serial_port_mode_reg[`BIT_INFRARED];
            request_pin_mode <= serial_port_mode_reg[`BIT_REQ_PIN_MODE];
            // Start bit is a low level on the receive line while asleep
            wake_request <= port_on & device_sleep & serial_port_mode_reg[`BIT_WAKE] &
                            ~serial_receive_pin;
            loopback_select <= serial_port_mode_reg[`BIT_LOOPBACK];
            auto_rate_detect <= serial_port_mode_reg[`BIT_AUTO_RATE];
            receive_polarity_invert <= serial_port_mode_reg[`BIT_RX_INVERT];
            high_speed_rate <= serial_port_mode_reg[`BIT_HIGH_SPEED];
            parity_width_select <= serial_port_mode_reg[`PAR_HI:`PAR_LO];
            stop_bits_select <= serial_port_mode_reg[`BIT_STOP_SEL];
        end
    end

endmodule

// ===== verif/uart_mode_control_checker.sv
// Checker for the serial port mode block, bound to its top ports.
// Assumes one clock domain and the registered output timing of the block.
`timescale 1ns/1ps
module uart_mode_control_checker (
    // Clock, reset and level inputs
    input logic hclk, hresetn, device_idle, device_sleep, transmit_enable,
    input logic core_rts, core_bclk, serial_receive_pin,
    // Pin ownership and control outputs
    input logic tx_pin_own, rx_pin_own, rts_pin_own, cts_pin_own, bclk_pin_own,
    input logic serial_transmit_pin, request_to_send_pin, baud_clock_pin,
    input logic core_cts, core_run, wake_request, loopback_select
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // Ownership follows the enable and the selected pin set
    AST_OFF_RELEASE: assert property (!$past(device_idle) && !core_run |->
        !(tx_pin_own || rx_pin_own || rts_pin_own || cts_pin_own || bclk_pin_own)) else $error("pins held while off");
    AST_TX_OWN: assert property (tx_pin_own |-> $past(transmit_enable)) else $error("tx owned without enable");
    AST_TX_RX: assert property (tx_pin_own |-> rx_pin_own) else $error("tx owned without rx");
    AST_CTS_BCLK: assert property (!(cts_pin_own && bclk_pin_own)) else $error("cts and bclk both owned");
    AST_BCLK: assert property (baud_clock_pin |-> $past(core_bclk)) else $error("baud clock without core");
    AST_RTS: assert property (!request_to_send_pin |-> !$past(core_rts)) else $error("rts low without core");
    // ==========================================================
    // Loopback and wake
    AST_LOOP_TX: assert property (loopback_select |-> serial_transmit_pin) else $error("tx not idle in loop");
    AST_LOOP_CTS: assert property (loopback_select |-> !core_cts) else $error("cts seen in loop");
    AST_WAKE: assert property (wake_request |-> $past(device_sleep) && !$past(serial_receive_pin))
        else $error("wake without start bit in sleep");
endmodule
bind uart_mode_control uart_mode_control_checker i_chk (.*);

// ===== verif/far_serial_peer.sv
// Remote serial device: a receive line idle high and a clear-to-send echo.
// Assumes the bench raises start_bit to send a start bit.
`timescale 1ns/1ps
module far_serial_peer (
    input logic hclk, start_bit, request_to_send_pin,
    output logic serial_receive_pin, clear_to_send_pin
);
    // Line rests high between frames; peer grants when asked
    always @(posedge hclk) begin
        serial_receive_pin <= !start_bit;
        clear_to_send_pin <= request_to_send_pin;
    end
endmodule

// ===== verif/uart_mode_control_test.sv
// Self-checking bench for the serial port mode block over AHB-Lite.
// Assumes a zero-wait slave with mode at 0x0 and pin status at 0x4.
`timescale 1ns/1ps
module uart_mode_control_test;
    logic hclk=0, hresetn=0, hsel=0, hwrite=0, hready, hreadyout, hresp, start_bit=0;
    logic [31:0] haddr=0, hwdata=0, hrdata, rd;
    logic [1:0] htrans=0, parity_width_select;
    logic [2:0] hsize=3'h2;
    logic device_idle=0, device_sleep=0, transmit_enable=0, peripheral_pin_remap=0;
    logic core_tx_data=1, core_rts=1, core_bclk=0, serial_receive_pin, clear_to_send_pin;
    logic tx_pin_own, rx_pin_own, rts_pin_own, cts_pin_own, bclk_pin_own, core_run;
    logic serial_transmit_pin, request_to_send_pin, baud_clock_pin, core_rx_data, core_cts;
    logic infrared_codec_enable, request_pin_mode, wake_request, loopback_select, auto_rate_detect;
    logic receive_polarity_invert, high_speed_rate, stop_bits_select;
    logic [31:0] pin_exp [4] = '{32'h23, 32'h27, 32'h2F, 32'h33};
    logic [1:0] line_exp [4] = '{2'h1, 2'h0, 2'h0, 2'h3};
    int fail_count=0, comparisons=0;
    assign hready = hreadyout;
    uart_mode_control i_dut (.*);
    far_serial_peer i_peer (.*);
    initial forever #12.5 hclk = !hclk;
    // ==========================================================
    // Shared tasks
    task end_of_test;
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Waits for hready under a bound so a stuck slave ends the run
    task wait_ready;
        int n;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20);
        if (n == 20) begin fail_count++; end_of_test; end
    endtask
    task xfer(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        wait_ready;
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        wait_ready;
        rd = hrdata;
    endtask
    // Outputs follow a written register one edge after the data phase
    task wr(input logic [31:0] d); xfer(1, 0, d); repeat (2) @(posedge hclk); endtask
    // ==========================================================
    // Scenarios
    task reset_state;
        xfer(0, 0, 0); chk(rd, 32'h0);
        xfer(0, 8, 0); chk(rd, 32'h0);
        chk({core_run, tx_pin_own, loopback_select, infrared_codec_enable}, 32'h0);
        chk({hreadyout, hresp}, 32'h2);
    endtask
    task field_mask;
        wr(32'hFFFFFFFF); xfer(0, 0, 0); chk(rd, 32'h0000BBFF);
        wr(32'h0000002A); // Alternate format bits catch swapped fields
        chk({auto_rate_detect, receive_polarity_invert, high_speed_rate, parity_width_select, stop_bits_select}, 32'h2A);
    endtask
    task pin_codes;
        // Core drives active levels so owned pins show them and unowned ones rest
        transmit_enable <= 1; core_rts <= 0; core_bclk <= 1;
        for (int c = 0; c < 4; c++) begin
            wr(32'h8000 | (c << 8)); xfer(0, 4, 0); chk(rd, pin_exp[c]);
            chk({baud_clock_pin, request_to_send_pin}, line_exp[c]);
        end
        core_rts <= 1; core_bclk <= 0;
        peripheral_pin_remap <= 1; wr(32'h8300); xfer(0, 4, 0); chk(rd, 32'h2F);
        chk(core_cts, 32'h1);
        peripheral_pin_remap <= 0; transmit_enable <= 0;
        wr(32'h8000); xfer(0, 4, 0); chk(rd, 32'h22);
        wr(32'h0); xfer(0, 4, 0); chk(rd, 32'h0);
    endtask
    task idle_stop;
        device_idle <= 1; wr(32'hA000); chk(core_run, 0);
        wr(32'h8000); chk(core_run, 1);
        device_idle <= 0;
    endtask
    task modes;
        wr(32'h98C0); chk({infrared_codec_enable, request_pin_mode, loopback_select}, 3'h7);
        core_tx_data <= 0; repeat (2) @(posedge hclk);
        chk({core_rx_data, serial_transmit_pin}, 2'h1);
        core_tx_data <= 1; device_sleep <= 1; start_bit <= 1; repeat (3) @(posedge hclk);
        chk(wake_request, 1);
        wr(32'h8040); chk(wake_request, 0);
        start_bit <= 0; device_sleep <= 0; wr(32'h0);
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        reset_state;
        field_mask;
        pin_codes;
        idle_stop;
        modes;
        end_of_test;
    end
endmodule
